/* ata_wr_handler.sv */
// Purpose: device-side task-file write command handler
// Assumes: one clock, media logic answers each sector with ack or err
// Notes: one data-port write carries one 16-bit word, 256 per sector
//
// Overview of operation
// - code 61h is a queued write, data flows host to device
// - forced unit access set: data committed to media before completion
// - forced unit access clear: completion may precede media commit
// - queued write: features hold count, zero is 65536; count holds tag
// - block write C5h asserts busy within 400 ns
// - block write interrupts once per block, data request at block start
// - count is in sectors; full blocks then one partial block
// - block write aborts if no block size or block writes disabled
// - error stops at failing sector; later blocks not transferred
// - on error address shows failing sector, count shows residual sectors
// - only block size one supported and reported to software
// - extended block write 39h needs LBA, 48-bit address, 16-bit count
// - high-order-byte select reaches upper byte of each 16-bit field
// - any task-file read or write clears high-order-byte select
// - extended error reports 48-bit address and 16-bit residual
// - sector write 30h moves 1 to 256 sectors, zero means 256
// - sector write: busy, then data request; no interrupt before data
// - per sector: busy set; next buffer ready: request and interrupt
// - after last sector busy holds until completion, then interrupt
// - failing sector address stays readable after multi-sector error
`timescale 1ns/1ns
`default_nettype none
module ata_wr_handler
  import ata_wr_pkg::*;
(
  input wire logic clk_i, // 10 MHz clock
  input wire logic rst_i, // sync reset, active high
  input wire logic [7:0] adr_i, // wishbone byte address
  input wire logic [31:0] dat_i, // wishbone write data
  output logic [31:0] dat_o, // wishbone read data
  input wire logic we_i, // wishbone write enable
  input wire logic [3:0] sel_i, // wishbone byte selects
  input wire logic cyc_i, // wishbone cycle
  input wire logic stb_i, // wishbone strobe
  output logic ack_o, // wishbone acknowledge
  output logic intrq_o, // ata interrupt request level
  output media_req_t media_req_o, // sector target for media
  output logic media_wr_o, // pulse: commit one sector
  input wire logic media_ack_i, // sector committed
  input wire logic media_err_i, // sector failed
  output logic [15:0] wd_o, // write data word to buffer
  output logic wd_vld_o // pulse: wd_o valid
);
  localparam int BSY_N = BSY_CYC;

  state_t st_q;
  logic ack_q, hob_q, men_q, bsy_q, drq_q, int_q, errf_q;
  logic fua_q, ok_q, ext_q, med_q;
  logic [31:0] dat_q, rdat;
  logic [7:0] dh_q, mult_q, err_q, blk_q, bcnt_q, wcnt_q, cmd_q;
  logic [15:0] hi_q, mid_q, lo_q, cnt_q, feat_q;
  logic [47:0] lba_q, n_lba;
  logic [16:0] rem_q, n_cnt;
  logic [7:0] n_blk;
  logic [4:0] tag_q;
  logic n_ok, n_ext, acc, wr, rd, tf, cmd_go, fin;
  logic [47:0] l48, l28;

  function automatic logic [15:0] wbyte(input logic [15:0] o, input logic [7:0] b,
                                        input logic h);
    wbyte = h ? {b, o[7:0]} : {o[15:8], b};
  endfunction

  function automatic logic [7:0] rbyte(input logic [15:0] v, input logic h);
    rbyte = h ? v[15:8] : v[7:0];
  endfunction

  // ******************************************
  // wishbone slave
  // ******************************************
  assign acc = cyc_i & stb_i & ~ack_q;
  assign wr = acc & we_i & sel_i[0];
  assign rd = acc & ~we_i;
  assign tf = acc && adr_i >= A_DH && adr_i <= A_FEAT;
  assign cmd_go = wr && adr_i == A_CMD && st_q == S_IDLE;
  assign ack_o = ack_q;
  assign dat_o = dat_q;
  assign intrq_o = int_q;
  assign media_req_o = '{lba: lba_q, fua: fua_q, tag: tag_q};

  always_comb begin
    rdat = '0;
    case (adr_i)
      A_DH: rdat[7:0] = dh_q;
      A_HI: rdat[7:0] = rbyte(hi_q, hob_q);
      A_MID: rdat[7:0] = rbyte(mid_q, hob_q);
      A_LO: rdat[7:0] = rbyte(lo_q, hob_q);
      A_CNT: rdat[7:0] = rbyte(cnt_q, hob_q);
      A_FEAT: rdat[7:0] = rbyte(feat_q, hob_q);
      A_DC: rdat[DC_HOB] = hob_q;
      A_STAT: begin
        rdat[ST_BSY] = bsy_q;
        rdat[ST_DRQ] = drq_q;
        rdat[ST_INT] = int_q;
        rdat[ST_ERR] = errf_q;
      end
      A_ERR: rdat[7:0] = err_q;
      A_CFG: rdat = {8'h00, BLK_MAX, 7'h00, men_q, mult_q};
      default: rdat = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= acc;
      if (rd) begin
        dat_q <= rdat;
      end
    end
  end

  // ******************************************
  // command decode
  // ******************************************
  assign l48 = {hi_q[15:8], mid_q[15:8], lo_q[15:8], hi_q[7:0], mid_q[7:0], lo_q[7:0]};
  assign l28 = {20'h00000, dh_q[3:0], hi_q[7:0], mid_q[7:0], lo_q[7:0]};

  always_comb begin
    n_ok = 1'b0;
    n_ext = 1'b0;
    n_lba = l28;
    n_cnt = (cnt_q[7:0] == 8'h00) ? N256 : {9'h000, cnt_q[7:0]};
    n_blk = mult_q;
    case (dat_i[7:0])
      CMD_SEC: begin
        n_ok = 1'b1;
        n_blk = BLK_MAX;
      end
      CMD_BLK: n_ok = mult_q != 8'h00 && men_q;
      CMD_BLK48: begin
        n_ok = mult_q != 8'h00 && men_q && dh_q[DH_LBA];
        n_ext = 1'b1;
        n_lba = l48;
        n_cnt = (cnt_q == 16'h0000) ? N65536 : {1'b0, cnt_q};
      end
      CMD_QWR: begin
        n_ok = 1'b1;
        n_ext = 1'b1;
        n_lba = l48;
        n_cnt = (feat_q == 16'h0000) ? N65536 : {1'b0, feat_q};
        n_blk = 8'h00;
      end
      default: n_ok = 1'b0;
    endcase
  end

  // ******************************************
  // task file, control and config
  // ******************************************
  assign fin = st_q == S_MEDIA && (media_err_i || (media_ack_i && rem_q == REM_ONE));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dh_q <= '0;
      hi_q <= '0;
      mid_q <= '0;
      lo_q <= '0;
      cnt_q <= '0;
      feat_q <= '0;
      hob_q <= 1'b0;
      mult_q <= '0;
      men_q <= 1'b0;
    end else begin
      if (wr && st_q == S_IDLE) begin
        case (adr_i)
          A_DH: dh_q <= dat_i[7:0];
          A_HI: hi_q <= wbyte(hi_q, dat_i[7:0], hob_q);
          A_MID: mid_q <= wbyte(mid_q, dat_i[7:0], hob_q);
          A_LO: lo_q <= wbyte(lo_q, dat_i[7:0], hob_q);
          A_CNT: cnt_q <= wbyte(cnt_q, dat_i[7:0], hob_q);
          A_FEAT: feat_q <= wbyte(feat_q, dat_i[7:0], hob_q);
          A_CFG: begin
            if (dat_i[7:0] <= BLK_MAX) begin
              mult_q <= dat_i[7:0];
            end
            men_q <= dat_i[CF_EN];
          end
          default: ;
        endcase
      end
      if (wr && adr_i == A_DC) begin
        hob_q <= dat_i[DC_HOB];
      end else if (tf) begin
        hob_q <= 1'b0;
      end
      if (fin) begin
        // failing or last sector address, residual count
        lo_q[7:0] <= lba_q[7:0];
        mid_q[7:0] <= lba_q[15:8];
        hi_q[7:0] <= lba_q[23:16];
        cnt_q <= media_err_i ? rem_q[15:0] : 16'h0000;
        if (ext_q) begin
          lo_q[15:8] <= lba_q[31:24];
          mid_q[15:8] <= lba_q[39:32];
          hi_q[15:8] <= lba_q[47:40];
        end else begin
          dh_q[3:0] <= lba_q[27:24];
        end
      end
    end
  end

  // ******************************************
  // command sequencer
  // ******************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= S_IDLE;
      bsy_q <= 1'b0;
      drq_q <= 1'b0;
      int_q <= 1'b0;
      errf_q <= 1'b0;
      err_q <= '0;
      ok_q <= 1'b0;
      ext_q <= 1'b0;
      fua_q <= 1'b0;
      tag_q <= '0;
      cmd_q <= '0;
      lba_q <= '0;
      rem_q <= '0;
      blk_q <= '0;
      bcnt_q <= '0;
      wcnt_q <= '0;
      med_q <= 1'b0;
    end else begin
      med_q <= 1'b0;
      if (rd && adr_i == A_STAT) begin
        int_q <= 1'b0;
      end
      case (st_q)
        S_IDLE: begin
          if (cmd_go) begin
            st_q <= S_BSY;
            bsy_q <= 1'b1;
            int_q <= 1'b0;
            errf_q <= 1'b0;
            err_q <= '0;
            cmd_q <= dat_i[7:0];
            ok_q <= n_ok;
            ext_q <= n_ext;
            lba_q <= n_lba;
            rem_q <= n_cnt;
            blk_q <= n_blk;
            bcnt_q <= n_blk;
            wcnt_q <= '0;
            fua_q <= dat_i[7:0] == CMD_QWR && dh_q[DH_FUA];
            tag_q <= cnt_q[7:3];
          end
        end
        S_BSY: begin
          bsy_q <= 1'b0;
          if (ok_q) begin
            st_q <= S_XFER;
            drq_q <= 1'b1;
          end else begin
            st_q <= S_IDLE;
            errf_q <= 1'b1;
            err_q[ER_ABRT] <= 1'b1;
            int_q <= 1'b1;
          end
        end
        S_XFER: begin
          if (wr && adr_i == A_DATA) begin
            wcnt_q <= wcnt_q + 8'h01;
            if (wcnt_q == SEC_LAST) begin
              st_q <= S_MEDIA;
              bsy_q <= 1'b1;
              drq_q <= 1'b0;
              med_q <= 1'b1;
            end
          end
        end
        S_MEDIA: begin
          // fua makes media ack mean committed, else cache may ack
          if (media_err_i) begin
            st_q <= S_IDLE;
            bsy_q <= 1'b0;
            errf_q <= 1'b1;
            err_q[ER_MED] <= 1'b1;
            int_q <= 1'b1;
          end else if (media_ack_i) begin
            if (rem_q == REM_ONE) begin
              st_q <= S_IDLE;
              bsy_q <= 1'b0;
              int_q <= 1'b1;
            end else begin
              st_q <= S_XFER;
              bsy_q <= 1'b0;
              drq_q <= 1'b1;
              lba_q <= lba_q + 48'h1;
              rem_q <= rem_q - REM_ONE;
              if (blk_q != 8'h00 && bcnt_q == 8'h01) begin
                bcnt_q <= blk_q;
                int_q <= 1'b1;
              end else begin
                bcnt_q <= bcnt_q - 8'h01;
              end
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // ******************************************
  // buffer and media strobes
  // ******************************************
  assign media_wr_o = med_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_o <= '0;
      wd_vld_o <= 1'b0;
    end else begin
      wd_vld_o <= wr && adr_i == A_DATA && st_q == S_XFER;
      if (wr && adr_i == A_DATA && st_q == S_XFER) begin
        wd_o <= dat_i[15:0];
      end
    end
  end

  // ******************************************
  // checks
  // ******************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_busy_window: assert property (cmd_go |-> ##[1:BSY_N] bsy_q)
    else $error("busy late after command");
  chk_queued_decode: assert property (cmd_go && dat_i[7:0] == CMD_QWR
      |-> ##2 drq_q && !bsy_q && st_q == S_XFER)
    else $error("queued write not started");
  chk_fua_take: assert property (cmd_go && dat_i[7:0] == CMD_QWR
      |=> fua_q == $past(dh_q[DH_FUA]))
    else $error("fua flag not taken");
  chk_count_zero: assert property (cmd_go && dat_i[7:0] == CMD_QWR && feat_q == 16'h0000
      |=> rem_q == N65536)
    else $error("zero count not 65536");
  chk_abort_nomult: assert property (cmd_go && dat_i[7:0] == CMD_BLK && mult_q == 8'h00
      |-> ##2 errf_q && err_q[ER_ABRT] && !bsy_q && int_q)
    else $error("block write not aborted");
  chk_no_first_int: assert property ($rose(drq_q) && $past(st_q) == S_BSY |-> !int_q)
    else $error("interrupt before first sector");
  chk_error_residual: assert property (st_q == S_MEDIA && media_err_i
      |=> cnt_q == $past(rem_q[15:0]) && errf_q && st_q == S_IDLE)
    else $error("residual count wrong on error");
  chk_final_done: assert property (st_q == S_MEDIA && !media_err_i && media_ack_i
      && rem_q == REM_ONE |=> !bsy_q && int_q && !drq_q && st_q == S_IDLE)
    else $error("completion not signalled");
  chk_block_int: assert property (st_q == S_MEDIA && !media_err_i && media_ack_i
      && rem_q != REM_ONE && blk_q != 8'h00 && bcnt_q == 8'h01 |=> int_q && drq_q)
    else $error("block interrupt missing");
  chk_media_busy: assert property (st_q == S_MEDIA |-> bsy_q && !drq_q)
    else $error("busy or request wrong during commit");
  chk_hob_clear: assert property (tf |=> !hob_q)
    else $error("hob not cleared");

  cov_queued_done: cover property (cmd_q == CMD_QWR && st_q == S_MEDIA && media_ack_i
    && rem_q == REM_ONE);
  cov_block_err: cover property (cmd_q == CMD_BLK48 && st_q == S_MEDIA && media_err_i);
  cov_abort: cover property (st_q == S_BSY && !ok_q);
endmodule
`default_nettype wire

/* ata_wr_pkg.sv */
// Purpose: shared constants and types for the task-file write handler
// Assumes: 10 MHz clock, classic wishbone register access
// Notes: register offsets are byte addresses of 32-bit words
package ata_wr_pkg;
  // ******************************************
  // command codes
  // ******************************************
  localparam logic [7:0] CMD_QWR = 8'h61;
  localparam logic [7:0] CMD_BLK = 8'hc5;
  localparam logic [7:0] CMD_BLK48 = 8'h39;
  localparam logic [7:0] CMD_SEC = 8'h30;
  // ******************************************
  // timing
  // ******************************************
  localparam int T_BSY_NS = 400;
  localparam int CLK_KHZ = 10000;
  localparam int BSY_CYC = (T_BSY_NS * CLK_KHZ / 1000000 < 1) ? 1 :
                           T_BSY_NS * CLK_KHZ / 1000000;
  // ******************************************
  // register offsets
  // ******************************************
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_DH = 8'h04;
  localparam logic [7:0] A_HI = 8'h08;
  localparam logic [7:0] A_MID = 8'h0c;
  localparam logic [7:0] A_LO = 8'h10;
  localparam logic [7:0] A_CNT = 8'h14;
  localparam logic [7:0] A_FEAT = 8'h18;
  localparam logic [7:0] A_DC = 8'h1c;
  localparam logic [7:0] A_STAT = 8'h20;
  localparam logic [7:0] A_ERR = 8'h24;
  localparam logic [7:0] A_CFG = 8'h28;
  localparam logic [7:0] A_DATA = 8'h2c;
  // ******************************************
  // field positions and values
  // ******************************************
  localparam int ST_BSY = 7;
  localparam int ST_DRQ = 3;
  localparam int ST_INT = 1;
  localparam int ST_ERR = 0;
  localparam int ER_ABRT = 2;
  localparam int ER_MED = 4;
  localparam int DH_FUA = 7;
  localparam int DH_LBA = 6;
  localparam int DC_HOB = 7;
  localparam int CF_EN = 8;
  localparam logic [7:0] BLK_MAX = 8'h01;
  localparam logic [7:0] SEC_LAST = 8'hff;
  localparam logic [16:0] N256 = 17'h00100;
  localparam logic [16:0] N65536 = 17'h10000;
  localparam logic [16:0] REM_ONE = 17'h00001;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_BSY = 2'b01,
    S_XFER = 2'b11,
    S_MEDIA = 2'b10
  } state_t;

  typedef struct packed {
    logic [47:0] lba;
    logic fua;
    logic [4:0] tag;
  } media_req_t;
endpackage

/* media_model.sv */
// Purpose: behavioural media store that answers sector commits
// Assumes: same clock as the handler, one commit outstanding at a time
// Notes: answer delay and failure are set by the bench
`timescale 1ns/1ns
`default_nettype none
module media_model (
  input wire logic clk_i, // clock
  input wire logic rst_i, // sync reset, active high
  input wire logic media_wr_i, // commit request pulse
  input wire logic fail_i, // answer the commit with an error
  input wire logic [2:0] lat_i, // answer delay in cycles
  output logic media_ack_o, // sector committed
  output logic media_err_o // sector failed
);
  logic [3:0] cnt_q;
  logic busy_q;

  // answer only after the commit delay has run out
  always_ff @(posedge clk_i) begin
    media_ack_o <= 1'b0;
    media_err_o <= 1'b0;
    if (rst_i) begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
    end else if (media_wr_i) begin
      busy_q <= 1'b1;
      cnt_q <= {1'b0, lat_i};
    end else if (busy_q) begin
      if (cnt_q == 4'h0) begin
        busy_q <= 1'b0;
        media_ack_o <= !fail_i;
        media_err_o <= fail_i;
      end else begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* tb.sv */
// Purpose: self-checking bench for the task-file write handler
// Assumes: wishbone answers one cycle after the request is taken
// Notes: expected results are queued and compared by a watcher
`timescale 1ns/1ns
`default_nettype none
module tb
  import ata_wr_pkg::*;
;
  typedef struct {string nm; logic [63:0] v; logic [63:0] m;} exp_t;
  logic clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, intrq_o, media_wr_o;
  logic media_ack_i, media_err_i, wd_vld_o, fail;
  logic [7:0] adr_i;
  logic [31:0] dat_i, dat_o;
  logic [3:0] sel_i;
  logic [2:0] lat;
  logic [15:0] wd_o;
  media_req_t media_req_o;
  exp_t rdq[$], wdq[$], mq[$], ev;
  int checked, mismatches, cycles, seed;
  localparam logic [47:0] L48 = 48'hab12_3456_789a;

  ata_wr_handler ata_wr_handler_i (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
    .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .intrq_o(intrq_o), .media_req_o(media_req_o),
    .media_wr_o(media_wr_o), .media_ack_i(media_ack_i), .media_err_i(media_err_i),
    .wd_o(wd_o), .wd_vld_o(wd_vld_o));
  media_model media_model_i (.clk_i(clk_i), .rst_i(rst_i), .media_wr_i(media_wr_o),
    .fail_i(fail), .lat_i(lat), .media_ack_o(media_ack_i), .media_err_o(media_err_i));

  // ********************************
  // checking and closing
  // ********************************
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0 && rdq.size() > 0) begin
      ev = rdq.pop_front();
      check(ev.nm, {32'h0, dat_o} & ev.m, ev.v & ev.m);
    end
    if (wd_vld_o === 1'b1 && wdq.size() > 0) begin
      ev = wdq.pop_front();
      check(ev.nm, {48'h0, wd_o}, ev.v);
    end
    if (media_wr_o === 1'b1 && mq.size() > 0) begin
      ev = mq.pop_front();
      check(ev.nm, {10'h0, media_req_o} & ev.m, ev.v & ev.m);
    end
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end

  // ********************************
  // bus and command helpers
  // ********************************
  task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w);
    adr_i <= a;
    dat_i <= d;
    we_i <= w;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, d, 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] v, input string nm,
                    input logic [31:0] m = 32'hff);
    rdq.push_back('{nm, {32'h0, v}, {32'h0, m}});
    bus(a, 32'h0, 1'b0);
  endtask

  task automatic sector(input logic [63:0] req, input logic [63:0] m);
    logic [15:0] w;
    lat <= 3'($random(seed));
    mq.push_back('{"media request", req, m});
    for (int i = 0; i < 256; i++) begin
      w = 16'($random(seed));
      wdq.push_back('{"write word", {48'h0, w}, 64'hffff});
      wr(A_DATA, {16'h0, w});
    end
  endtask

  task automatic run28(input logic [7:0] c, input logic [27:0] a, input int n, input int bad);
    int f;
    f = (bad < n) ? bad : n - 1;
    wr(A_DH, {24'h0, 4'h4, a[27:24]});
    wr(A_HI, {24'h0, a[23:16]});
    wr(A_MID, {24'h0, a[15:8]});
    wr(A_LO, {24'h0, a[7:0]});
    wr(A_CNT, 32'(n));
    wr(A_CMD, {24'h0, c});
    rd(A_STAT, 32'h08, "status at start");
    for (int s = 0; s <= f; s++) begin
      fail <= (s == bad);
      sector({30'h0, a + 28'(s), 6'h0}, 64'h3_ffff_ffc0);
      while (intrq_o !== 1'b1) @(posedge clk_i);
      if (s == bad) rd(A_STAT, 32'h03, "status on error");
      else if (s == n - 1) rd(A_STAT, 32'h02, "status at end");
      else rd(A_STAT, 32'h0a, "status between sectors");
    end
    fail <= 1'b0;
    rd(A_LO, {24'h0, 8'(a + 28'(f))}, "sector address");
    rd(A_CNT, (bad < n) ? 32'(n - bad) : 32'h0, "residual count");
  endtask

  // ********************************
  // main sequence
  // ********************************
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  initial begin
    seed = 32'h8c00;
    checked = 0;
    mismatches = 0;
    cycles = 0;
    {rst_i, adr_i, dat_i, we_i, sel_i, cyc_i, stb_i, fail, lat} = {1'b1, 51'h0};
    sel_i = 4'hf;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(A_CFG, 32'h10000, "config reset", 32'hff01ff);
    wr(A_CMD, {24'h0, CMD_BLK});
    rd(A_STAT, 32'h03, "status abort");
    rd(A_ERR, 32'h04, "abort code");
    wr(A_CFG, 32'h101);
    rd(A_CFG, 32'h10101, "config set", 32'hff01ff);
    wr(A_DH, 32'h0);
    wr(A_CMD, {24'h0, CMD_BLK48});
    rd(A_STAT, 32'h03, "status no lba");
    rd(A_ERR, 32'h04, "abort code no lba");
    $display("test aborts done");
    run28(CMD_SEC, 28'h51234fe, 2, 2);
    $display("test sector write done");
    run28(CMD_BLK, 28'h00abcde, 3, 1);
    rd(A_ERR, 32'h10, "media code");
    $display("test block write error done");
    for (int k = 0; k < 3; k++) begin
      wr(A_DC, 32'h80);
      wr(A_HI + 8'(4 * k), {24'h0, L48[47 - 8 * k -: 8]});
      wr(A_HI + 8'(4 * k), {24'h0, L48[23 - 8 * k -: 8]});
    end
    wr(A_DC, 32'h80);
    rd(A_HI, {24'h0, L48[47:40]}, "upper byte");
    rd(A_HI, {24'h0, L48[23:16]}, "lower byte");
    wr(A_FEAT, 32'h1);
    wr(A_CNT, 32'h28);
    wr(A_DH, 32'hc0);
    wr(A_CMD, {24'h0, CMD_QWR});
    rd(A_STAT, 32'h08, "queued start");
    sector({10'h0, L48, 1'b1, 5'h05}, 64'h3f_ffff_ffff_ffff);
    while (intrq_o !== 1'b1) @(posedge clk_i);
    rd(A_STAT, 32'h02, "queued completion");
    $display("test queued write done");
    // zero count means the longest transfer; cut short by a reset
    wr(A_FEAT, 32'h0);
    wr(A_CMD, {24'h0, CMD_QWR});
    rd(A_STAT, 32'h08, "queued long start");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(A_STAT, 32'h00, "status after reset");
    rd(A_CFG, 32'h10000, "config after reset", 32'hff01ff);
    $display("test reset mid-run done");
    close_out();
  end
endmodule
`default_nettype wire
